// ===== rtl/relative_branch_bitset_exec.sv
`timescale 1ns/1ps
`include "rbb_defines.svh"

module relative_branch_bitset_exec
  import rbb_pkg::*;
#(
  parameter int BANK_W = 4
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [15:0]       instr_in,
  input  wire logic              zero_flag_in,
  input  wire logic [BANK_W-1:0] bank_sel_in,
  input  wire logic              ext_set_en_in,
  input  wire logic [11:0]       index_base_in,
  input  wire logic [7:0]        rd_data_in,
  output logic      [20:0]       fetch_addr_out,
  output logic      [11:0]       data_addr_out,
  output logic                   data_rd_out,
  output logic                   data_wr_out,
  output logic      [7:0]        data_wdata_out,
  output logic                   branch_taken_out,
  output logic                   nop_cycle_out,
  output logic      [1:0]        phase_out
);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  st_t         s_r;
  st_t         s_nxt;
  logic        is_jmp;
  logic        is_jnz;
  logic        is_setb;
  logic [7:0]  f_fld;
  logic [20:0] off_jmp;
  logic [20:0] off_jnz;
  logic [11:0] addr_sel;

  // All checks share the core clock and release with reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // A flushed word is the discarded prefetch and decodes as nothing
  assign is_jmp  = !s_r.flush && (s_r.ir[15:11] == `RBB_JMP_OPC);
  assign is_jnz  = !s_r.flush && (s_r.ir[15:8] == `RBB_JNZ_OPC);
  assign is_setb = !s_r.flush && (s_r.ir[15:12] == `RBB_SETB_OPC);
  assign f_fld   = s_r.ir[7:0];
  // Offsets are counted in words, the program counter in bytes
  assign off_jmp = {{9{s_r.ir[10]}}, s_r.ir[10:0], 1'b0};
  assign off_jnz = {{12{s_r.ir[7]}}, s_r.ir[7:0], 1'b0};

  property p_jmp_decode;
    (s_r.q == PH_Q1) && !s_r.flush && (s_r.ir[15:11] == `RBB_JMP_OPC) |=> (s_r.op == OP_JMP) && s_r.take;
  endproperty
  a_jmp_decode: assert property (p_jmp_decode) else $error("jump not decoded");

  property p_jnz_enc;
    (s_r.q == PH_Q1) && !s_r.flush && (s_r.ir[15:8] == `RBB_JNZ_OPC) |=> (s_r.op == OP_JNZ);
  endproperty
  a_jnz_enc: assert property (p_jnz_enc) else $error("nonzero branch not decoded");

  // ************************************************************
  // Data address selection
  // ************************************************************
  // Access bank splits at 60h: low part from bank 0, upper part from the top bank.
  // The indexed base is added without carry out; wrap past the top is the user's concern.
  assign addr_sel = s_r.ir[8] ? 12'({bank_sel_in, f_fld}) :
                    (ext_set_en_in && (f_fld <= `RBB_ILO_MAX)) ? (index_base_in + {4'h0, f_fld}) :
                    (f_fld <= `RBB_ILO_MAX) ? {`RBB_ACC_LO_BANK, f_fld} :
                    {`RBB_ACC_HI_BANK, f_fld};

  property p_bank_sel;
    (s_r.q == PH_Q1) && is_setb && s_r.ir[8] |=> s_r.daddr == 12'({$past(bank_sel_in), $past(f_fld)});
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("banked address wrong");

  property p_indexed;
    (s_r.q == PH_Q1) && is_setb && !s_r.ir[8] && ext_set_en_in && (f_fld <= `RBB_ILO_MAX)
      |=> s_r.daddr == ($past(index_base_in) + {4'h0, $past(f_fld)});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  // ************************************************************
  // Quarter-phase sequencer
  // ************************************************************
  always_comb begin
    s_nxt             = s_r;
    s_nxt.taken_pulse = 1'b0;
    case (s_r.q)
      PH_Q1: begin
        s_nxt.q         = PH_Q2;
        s_nxt.nop_cycle = s_r.flush;
        s_nxt.bit_idx   = s_r.ir[11:9];
        s_nxt.daddr     = addr_sel;
        s_nxt.rd        = is_setb;
        if (is_jmp) begin
          s_nxt.op     = OP_JMP;
          s_nxt.target = s_r.pc + off_jmp;
          s_nxt.take   = 1'b1;
        end else if (is_jnz) begin
          s_nxt.op     = OP_JNZ;
          s_nxt.target = s_r.pc + off_jnz;
          s_nxt.take   = !zero_flag_in;
        end else if (is_setb) begin
          s_nxt.op   = OP_SETB;
          s_nxt.take = 1'b0;
        end else begin
          s_nxt.op   = OP_NONE;
          s_nxt.take = 1'b0;
        end
      end
      PH_Q2: begin
        s_nxt.q     = PH_Q3;
        s_nxt.rd    = 1'b0;
        // Read-modify-write: only the addressed bit changes
        s_nxt.wdata = rd_data_in | (8'h01 << s_r.bit_idx);
      end
      PH_Q3: begin
        s_nxt.q  = PH_Q4;
        s_nxt.wr = (s_r.op == OP_SETB);
      end
      PH_Q4: begin
        s_nxt.q           = PH_Q1;
        s_nxt.wr          = 1'b0;
        s_nxt.ir          = instr_in;
        // The word fetched alongside a taken branch is kept only to be skipped
        s_nxt.flush       = s_r.take;
        s_nxt.pc          = s_r.take ? s_r.target : (s_r.pc + `RBB_PC_STEP);
        s_nxt.taken_pulse = s_r.take;
        s_nxt.take        = 1'b0;
        s_nxt.op          = OP_NONE;
      end
      default: begin
        s_nxt.q = PH_Q1;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fetch_addr_out   = s_r.pc;
  assign data_addr_out    = s_r.daddr;
  assign data_rd_out      = s_r.rd;
  assign data_wr_out      = s_r.wr;
  assign data_wdata_out   = s_r.wdata;
  assign branch_taken_out = s_r.taken_pulse;
  assign nop_cycle_out    = s_r.nop_cycle;
  assign phase_out        = s_r.q;

  // ************************************************************
  // Sequencer checks
  // ************************************************************
  property p_jmp_target;
    (s_r.q == PH_Q1) && is_jmp |=> s_r.target == ($past(s_r.pc) + $past(off_jmp));
  endproperty
  a_jmp_target: assert property (p_jmp_target) else $error("jump target wrong");

  property p_jmp_two;
    (s_r.q == PH_Q1) && is_jmp |=> ##3 (s_r.pc == $past(s_r.target)) ##1 s_r.flush ##1 s_r.nop_cycle;
  endproperty
  a_jmp_two: assert property (p_jmp_two) else $error("jump second cycle not a no-op");

  property p_nop_quiet;
    (s_r.q == PH_Q1) && s_r.flush |=> !s_r.rd ##2 !s_r.wr;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("discarded word touched data");

  property p_setb_read;
    (s_r.q == PH_Q1) && is_setb |=> s_r.rd ##1 !s_r.rd;
  endproperty
  a_setb_read: assert property (p_setb_read) else $error("bit set read strobe wrong");

  property p_setb_write;
    (s_r.q == PH_Q1) && is_setb |=> ##2 s_r.wr && s_r.wdata[s_r.bit_idx] && (s_r.daddr == $past(addr_sel, 3));
  endproperty
  a_setb_write: assert property (p_setb_write) else $error("bit set write missing");

  property p_jnz_taken;
    (s_r.q == PH_Q1) && is_jnz && !zero_flag_in |=> s_r.take && (s_r.target == ($past(s_r.pc) + $past(off_jnz)));
  endproperty
  a_jnz_taken: assert property (p_jnz_taken) else $error("nonzero branch not taken");

  property p_jnz_not;
    (s_r.q == PH_Q1) && is_jnz && zero_flag_in
      |=> ##3 !s_r.flush && (s_r.pc == $past(s_r.pc, 4) + `RBB_PC_STEP);
  endproperty
  a_jnz_not: assert property (p_jnz_not) else $error("untaken branch cost a cycle");

  property p_flush;
    (s_r.q == PH_Q4) && s_r.take
      |=> s_r.flush && s_r.taken_pulse ##1 (s_r.op == OP_NONE) && !s_r.rd && s_r.nop_cycle;
  endproperty
  a_flush: assert property (p_flush) else $error("prefetched word not discarded");

endmodule

// ===== shared/rbb_defines.svh
// Function
// - Unconditional jump decodes from top bits 11010, low eleven bits signed offset.
// - Jump loads incremented PC plus twice the signed offset.
// - Jump takes two cycles, second is a no-op; flags unchanged.
// - Bit set decodes 1000, bit index, bank flag, register; sets bit in one cycle.
// - Bank flag 0 uses access bank; flag 1 uses bank pointer plus register field.
// - Flag 0 with extended set enabled, registers up to 5Fh are indexed offsets.
// - Jump-if-nonzero branches to its relative target when zero flag is 0.
// - Jump-if-nonzero pattern 1110 0001 plus 8-bit offset; target PC plus 2n.
// - Conditional branch: one cycle not taken, two when taken, extra is no-op.
`ifndef RBB_DEFINES_SVH
`define RBB_DEFINES_SVH

// ************************************************************
// Encodings
// ************************************************************
`define RBB_JMP_OPC     5'h1A
`define RBB_JNZ_OPC     8'hE1
`define RBB_SETB_OPC    4'h8
`define RBB_NOP_WORD    16'h0000

// ************************************************************
// Addressing
// ************************************************************
`define RBB_ILO_MAX     8'h5F
`define RBB_ACC_LO_BANK 4'h0
`define RBB_ACC_HI_BANK 4'hF
`define RBB_PC_STEP     21'h000002
`define RBB_PC_RST      21'h000000

`endif

// ===== shared/rbb_pkg.sv
package rbb_pkg;
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_JMP  = 2'b01,
    OP_JNZ  = 2'b10,
    OP_SETB = 2'b11
  } op_t;

  typedef struct packed {
    phase_t      q;
    logic [20:0] pc;
    logic [15:0] ir;
    logic        flush;
    op_t         op;
    logic [2:0]  bit_idx;
    logic [11:0] daddr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic [20:0] target;
    logic        take;
    logic        taken_pulse;
    logic        nop_cycle;
  } st_t;
endpackage

// ===== dv/prog_mem_model.sv
`timescale 1ns/1ps

module prog_mem_model (
  input  wire logic [20:0] addr_in,
  output logic      [15:0] word_out
);
  // ****************************************
  // Program image
  // ****************************************
  logic [15:0] mem [256];

  // Byte address, word wide: bit 0 ignored, image repeats every 512 bytes
  assign word_out = mem[addr_in[8:1]];
endmodule

// ===== dv/relative_branch_bitset_exec_test.sv
`timescale 1ns/1ps

module relative_branch_bitset_exec_test import rbb_pkg::*;;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] instr_in;
  logic        zero_flag_in = 1'b0;
  logic [3:0]  bank_sel_in = 4'h0;
  logic        ext_set_en_in = 1'b0;
  logic [11:0] index_base_in = 12'h000;
  logic [7:0]  rd_data_in = 8'h00;
  logic [20:0] fetch_addr_out;
  logic [11:0] data_addr_out;
  logic        data_rd_out, data_wr_out, branch_taken_out, nop_cycle_out;
  logic [7:0]  data_wdata_out;
  logic [1:0]  phase_out;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          seed = 32'h8137;
  logic [31:0] r;
  logic [20:0] fa = 21'h000000;
  logic [15:0] w = 16'h0000;
  logic        fl = 1'b0;
  logic        tkp = 1'b0;

  relative_branch_bitset_exec relative_branch_bitset_exec_i (.clk_in, .rst_in, .instr_in, .zero_flag_in,
    .bank_sel_in, .ext_set_en_in, .index_base_in, .rd_data_in, .fetch_addr_out, .data_addr_out,
    .data_rd_out, .data_wr_out, .data_wdata_out, .branch_taken_out, .nop_cycle_out, .phase_out);
  prog_mem_model prog_mem_model_i (.addr_in(fetch_addr_out), .word_out(instr_in));

  initial forever #25 clk_in = ~clk_in;

  // ****************************************
  // Reference and checks
  // ****************************************
  function automatic logic [11:0] ea_f(logic [15:0] wd, logic [3:0] bk, logic x, logic [11:0] ib);
    if (wd[8]) return {bk, wd[7:0]};
    if (wd[7:0] <= 8'h5F) return x ? ib + {4'h0, wd[7:0]} : {4'h0, wd[7:0]};
    return {4'hF, wd[7:0]};
  endfunction

  function automatic logic [20:0] tg_f(logic [20:0] f, logic [15:0] wd);
    if (wd[15:11] == 5'h1A) return f + {{9{wd[10]}}, wd[10:0], 1'b0};
    return f + {{12{wd[7]}}, wd[7:0], 1'b0};
  endfunction

  task automatic chk(string nm, logic [20:0] e, logic [20:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One instruction cycle, entered at the edge that opens Q1
  task automatic cyc();
    logic [15:0] nw;
    logic        bs;
    logic        tk;
    zero_flag_in  <= 1'($random(seed));
    bank_sel_in   <= 4'($random(seed));
    ext_set_en_in <= 1'($random(seed));
    index_base_in <= 12'($random(seed));
    rd_data_in    <= 8'($random(seed));
    bs = !fl && w[15:12] == 4'h8;
    @(negedge clk_in);
    chk("taken", tkp, branch_taken_out);
    @(negedge clk_in);
    chk("phase", PH_Q2, phase_out);
    chk("fetch", fa, fetch_addr_out);
    chk("nop", fl, nop_cycle_out);
    chk("rd", bs, data_rd_out);
    if (bs) chk("daddr", ea_f(w, bank_sel_in, ext_set_en_in, index_base_in), data_addr_out);
    repeat (2) @(negedge clk_in);
    chk("wr", bs, data_wr_out);
    if (bs) chk("wdata", rd_data_in | (8'h01 << w[11:9]), data_wdata_out);
    nw = prog_mem_model_i.mem[fa[8:1]];
    @(posedge clk_in);
    tk = !fl && (w[15:11] == 5'h1A || (w[15:8] == 8'hE1 && !zero_flag_in));
    fa = tk ? tg_f(fa, w) : fa + 21'h000002;
    fl = tk;
    tkp = tk;
    w = nw;
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    for (int i = 0; i < 256; i++) begin
      r = $random(seed);
      case (r[1:0])
        2'h0: prog_mem_model_i.mem[i] = {5'h1A, r[12:2]};
        2'h1: prog_mem_model_i.mem[i] = {8'hE1, r[9:2]};
        2'h2: prog_mem_model_i.mem[i] = {4'h8, r[13:2]};
        // Foreign opcodes must pass as plain one-cycle words
        default: prog_mem_model_i.mem[i] = {4'h0, r[13:2]};
      endcase
    end
    // Extreme offsets and both sides of the indexed boundary
    prog_mem_model_i.mem[0] = 16'hD400;
    prog_mem_model_i.mem[1] = 16'hE180;
    prog_mem_model_i.mem[2] = 16'h805F;
    prog_mem_model_i.mem[3] = 16'h8E60;
    repeat (19) @(posedge clk_in);
    @(negedge clk_in);
    chk("reset", 21'h000000, fetch_addr_out);
    @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (400) cyc();
    final_report();
  end

  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule
